// *** design/iosi_device.sv ***
// Function
// - Each channel command drives its channel.
// - Capture strobe low latches channel commands.
// - Transfer strobe low fills transmission buffer, transfers.
// - Periodic refresh, suppressed in transfer-only phase.
// - Both strobes low: outputs follow commands.
// - Output enable low forces all outputs off.
// - Host holds output enable low long enough.
// - Watchdog timeout disables outputs until update.
// - Each good refresh restarts the watchdog.
// - Capture phase leaves outputs unchanged.
// - Transfer phase held minimum; pending transfer completes.
// - Transfer strobe rise applies stored configuration.
// - Fixed apply latency keeps devices aligned.
// - Host never drives both strobes low strobed.
// - Output enable low clears data until resequenced.
// - Fault asserts on junction or case trip.
// - Fault asserts on corrupted barrier data.
// - Errors hold outputs; refresh error turns off.
// - Thermal fault updated only at transfers.
`timescale 1ns/100ps
module iosi_device #(
  parameter int unsigned WD_CYC      = iosi_pkg::IOSI_WD_CYC,
  parameter int unsigned REFRESH_CYC = iosi_pkg::IOSI_REFRESH_CYC,
  parameter int unsigned XFER_CYC    = iosi_pkg::IOSI_XFER_CYC
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // Host link
  iosi_if.dev                                link,
  // Process side
  output logic [iosi_pkg::IOSI_NCH-1:0]      channel_drive,
  input  wire logic [iosi_pkg::IOSI_NCH-1:0] junction_trip,
  input  wire logic                          case_trip,
  input  wire logic                          barrier_corrupt
);
  import iosi_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int unsigned SW = 2 * IOSI_NCH + 5;
  // Strobes and enable reset to their idle high level, so that no false
  // direct-drive or disable phase follows the release of reset.
  localparam logic [SW-1:0] SYNC_RST =
    {{(IOSI_NCH+2){1'b0}}, 3'h7, IOSI_CH_RST};

  logic [SW-1:0]       raw;
  logic [SW-1:0]       sync1;
  logic [SW-1:0]       sync2;
  logic [IOSI_NCH-1:0] cmd;
  logic [IOSI_NCH-1:0] jtrip;
  logic                load_lo;
  logic                sync_lo;
  logic                oe;
  logic                ctrip;
  logic                corrupt;

  assign raw = {barrier_corrupt, case_trip, junction_trip,
                link.out_en, link.sync_n, link.load_n, link.channel_cmd};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= SYNC_RST;
      sync2 <= SYNC_RST;
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
    end
  end

  assign cmd     = sync2[IOSI_NCH-1:0];
  assign load_lo = ~sync2[IOSI_NCH];
  assign sync_lo = ~sync2[IOSI_NCH+1];
  assign oe      = sync2[IOSI_NCH+2];
  assign jtrip   = sync2[2*IOSI_NCH+2:IOSI_NCH+3];
  assign ctrip   = sync2[2*IOSI_NCH+3];
  assign corrupt = sync2[2*IOSI_NCH+4];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [IOSI_NCH-1:0] in_buf;
  logic [IOSI_NCH-1:0] tx_buf;
  logic [IOSI_NCH-1:0] xfer_data;
  logic [IOSI_NCH-1:0] out_reg;
  logic                sync_lo_q;
  logic                load_lo_q;
  logic                busy;
  logic                xfer_refresh;
  logic                tx_sent;
  logic                ref_pend;
  logic                wd_off;
  logic                therm_stat;
  logic                comm_err;
  logic [IOSI_CW-1:0]  xcnt;
  logic [IOSI_CW-1:0]  rcnt;
  logic [IOSI_CW-1:0]  wcnt;

  // ----------------------------------------------------------------
  // Strobe decode
  // ----------------------------------------------------------------
  wire direct_drive_mode = load_lo & sync_lo;
  wire capture           = load_lo & ~sync_lo;
  wire xfer_phase        = ~load_lo & sync_lo;
  wire oe_off            = ~oe;
  // Rise of the transfer strobe out of the transfer-only phase.
  wire sync_rise = ~sync_lo & sync_lo_q & ~load_lo & ~load_lo_q;

  wire refresh_due = (rcnt == IOSI_CW'(REFRESH_CYC - 1));
  wire xfer_done   = busy & (xcnt == IOSI_CW'(XFER_CYC - 1));
  wire xfer_good   = xfer_done & ~corrupt;
  wire xfer_bad    = xfer_done & corrupt;
  // A transfer in flight is allowed to finish before the strobed one.
  wire start_sync  = xfer_phase & ~busy & ~tx_sent & oe;
  wire start_ref   = ref_pend & ~busy & ~xfer_phase & oe;
  wire update_ok   = direct_drive_mode | sync_rise |
                     (xfer_good & xfer_refresh);
  wire wd_expire   = (wcnt == IOSI_CW'(WD_CYC - 1));

  // ----------------------------------------------------------------
  // Input and transmission buffers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_buf <= IOSI_CH_RST;
    end else if (direct_drive_mode || capture) begin
      in_buf <= cmd;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_buf <= IOSI_CH_RST;
    end else if (oe_off) begin
      tx_buf <= IOSI_CH_RST;
    end else if (direct_drive_mode) begin
      tx_buf <= cmd;
    end else if (xfer_phase) begin
      tx_buf <= in_buf;
    end
  end

  // ----------------------------------------------------------------
  // Refresh timer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rcnt     <= '0;
      ref_pend <= 1'b0;
    end else begin
      rcnt <= refresh_due ? '0 : rcnt + 1'b1;
      if (refresh_due) begin
        ref_pend <= 1'b1;
      end else if (start_ref) begin
        ref_pend <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Barrier transfer
  // ----------------------------------------------------------------
  // Output enable low aborts a transfer so stale data cannot return.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy         <= 1'b0;
      xcnt         <= '0;
      xfer_refresh <= 1'b0;
      xfer_data    <= IOSI_CH_RST;
      tx_sent      <= 1'b0;
    end else begin
      if (oe_off || xfer_done) begin
        busy <= 1'b0;
      end else if (start_sync || start_ref) begin
        busy         <= 1'b1;
        xfer_refresh <= start_ref;
        xfer_data    <= start_sync ? in_buf : tx_buf;
      end else if (direct_drive_mode) begin
        // A refresh in flight must not bring back older outputs.
        xfer_data <= cmd;
      end
      xcnt <= (busy && !xfer_done) ? xcnt + 1'b1 : '0;
      if (!xfer_phase) begin
        tx_sent <= 1'b0;
      end else if (start_sync) begin
        tx_sent <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output data register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_reg   <= IOSI_CH_RST;
      sync_lo_q <= 1'b0;
      load_lo_q <= 1'b0;
    end else begin
      sync_lo_q <= sync_lo;
      load_lo_q <= load_lo;
      if (oe_off) begin
        out_reg <= IOSI_CH_RST;
      end else if (direct_drive_mode) begin
        out_reg <= cmd;
      end else if (sync_rise) begin
        out_reg <= tx_buf;
      end else if (xfer_bad && xfer_refresh) begin
        out_reg <= IOSI_CH_RST;
      end else if (xfer_good && xfer_refresh) begin
        out_reg <= xfer_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Process side watchdog
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wcnt   <= '0;
      wd_off <= 1'b0;
    end else if (update_ok) begin
      wcnt   <= '0;
      wd_off <= 1'b0;
    end else if (wd_expire) begin
      wd_off <= 1'b1;
    end else begin
      wcnt <= wcnt + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Fault status and drive
  // ----------------------------------------------------------------
  // Thermal status is only sampled at transfers and may lag the die.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      therm_stat <= 1'b0;
      comm_err   <= 1'b0;
    end else if (xfer_done) begin
      therm_stat <= (|jtrip) | ctrip;
      comm_err   <= corrupt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_drive   <= IOSI_CH_RST;
      link.fault_oe_n <= 1'b1;
    end else begin
      // Channel thermal cut-off acts at once, not at transfers.
      channel_drive   <= out_reg & ~jtrip & {IOSI_NCH{~wd_off}};
      link.fault_oe_n <= ~(therm_stat | comm_err);
    end
  end

  assign link.fault_drv = 1'b0;

endmodule // iosi_device

// *** design/iosi_host.sv ***
`timescale 1ns/100ps
module iosi_host #(
  parameter int unsigned LOAD_CYC = iosi_pkg::IOSI_LOAD_MIN_CYC,
  parameter int unsigned SYNC_CYC = iosi_pkg::IOSI_SYNC_MIN_CYC,
  parameter int unsigned OE_CYC   = iosi_pkg::IOSI_OE_MIN_CYC
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // Device link
  iosi_if.host                               link,
  // User side
  input  wire logic                          mode_direct,
  input  wire logic [iosi_pkg::IOSI_NCH-1:0] cmd_data,
  input  wire logic                          update_req,
  input  wire logic                          disable_req,
  output logic                               busy,
  output logic                               fault
);
  import iosi_pkg::*;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  iosi_state_t        state;
  logic [IOSI_CW-1:0] cnt;
  logic               f1;
  logic               f2;

  wire load_end = (cnt == IOSI_CW'(LOAD_CYC - 1));
  wire sync_end = (cnt == IOSI_CW'(SYNC_CYC - 1));
  wire oe_end   = (cnt == IOSI_CW'(OE_CYC - 1));

  assign busy = (state != IOSI_IDLE);

  // Capture and transfer phases swap in one edge, never both low.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state            <= IOSI_IDLE;
      cnt              <= '0;
      link.load_n      <= 1'b1;
      link.sync_n      <= 1'b1;
      link.out_en      <= 1'b1;
      link.channel_cmd <= IOSI_CH_RST;
    end else begin
      cnt <= cnt + 1'b1;
      unique case (state)
        IOSI_IDLE: begin
          cnt <= '0;
          if (disable_req) begin
            link.out_en <= 1'b0;
            state       <= IOSI_DISABLE;
          end else if (update_req) begin
            link.channel_cmd <= cmd_data;
            link.load_n      <= 1'b0;
            link.sync_n      <= ~mode_direct;
            state <= mode_direct ? IOSI_DIRECT : IOSI_CAPTURE;
          end
        end
        IOSI_DIRECT: begin
          if (load_end) begin
            link.load_n <= 1'b1;
            link.sync_n <= 1'b1;
            state       <= IOSI_IDLE;
          end
        end
        IOSI_CAPTURE: begin
          if (load_end) begin
            link.load_n <= 1'b1;
            link.sync_n <= 1'b0;
            cnt         <= '0;
            state       <= IOSI_TRANSFER;
          end
        end
        IOSI_TRANSFER: begin
          if (sync_end) begin
            link.sync_n <= 1'b1;
            state       <= IOSI_IDLE;
          end
        end
        IOSI_DISABLE: begin
          if (oe_end) begin
            link.out_en <= 1'b1;
            state       <= IOSI_IDLE;
          end
        end
        default: begin
          state <= IOSI_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Fault line synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      f1    <= 1'b1;
      f2    <= 1'b1;
      fault <= 1'b0;
    end else begin
      f1    <= link.fault_n;
      f2    <= f1;
      fault <= ~f2;
    end
  end

endmodule // iosi_host

// *** design/iosi_if.sv ***
`timescale 1ns/100ps
interface iosi_if;
  import iosi_pkg::*;

  logic [IOSI_NCH-1:0] channel_cmd;
  logic                load_n;
  logic                sync_n;
  logic                out_en;
  logic                fault_drv;
  logic                fault_oe_n;
  logic                fault_n;

  // Open-drain fault line with its pull-up.
  assign fault_n = fault_oe_n ? 1'b1 : fault_drv;

  modport dev (
    input  channel_cmd,
    input  load_n,
    input  sync_n,
    input  out_en,
    output fault_drv,
    output fault_oe_n
  );

  modport host (
    output channel_cmd,
    output load_n,
    output sync_n,
    output out_en,
    input  fault_n
  );

endinterface

// *** design/iosi_pkg.sv ***
package iosi_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned IOSI_NCH = 8;
  localparam int unsigned IOSI_CW  = 16;

  // ----------------------------------------------------------------
  // Clock and times
  // ----------------------------------------------------------------
  localparam int unsigned IOSI_CLK_HZ     = 50_000_000;
  localparam int unsigned IOSI_CLK_NS     = 20;
  localparam int unsigned IOSI_REFRESH_HZ = 15_000;
  localparam int unsigned IOSI_WD_US      = 272;
  localparam int unsigned IOSI_OE_MIN_NS  = 1_000;
  localparam int unsigned IOSI_SYNC_MIN_NS = 10_000;
  localparam int unsigned IOSI_LOAD_MIN_NS = 100;

  // ----------------------------------------------------------------
  // Derived cycle counts
  // ----------------------------------------------------------------
  localparam int unsigned IOSI_REFRESH_CYC = IOSI_CLK_HZ / IOSI_REFRESH_HZ;
  localparam int unsigned IOSI_WD_CYC =
    IOSI_WD_US * (IOSI_CLK_HZ / 1_000_000);
  localparam int unsigned IOSI_OE_MIN_CYC =
    (IOSI_OE_MIN_NS + IOSI_CLK_NS - 1) / IOSI_CLK_NS;
  localparam int unsigned IOSI_SYNC_MIN_CYC =
    (IOSI_SYNC_MIN_NS + IOSI_CLK_NS - 1) / IOSI_CLK_NS;
  localparam int unsigned IOSI_LOAD_MIN_CYC =
    (IOSI_LOAD_MIN_NS + IOSI_CLK_NS - 1) / IOSI_CLK_NS;
  localparam int unsigned IOSI_XFER_CYC = 20;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [IOSI_NCH-1:0] IOSI_CH_RST = 8'h00;

  // ----------------------------------------------------------------
  // Host sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    IOSI_IDLE     = 3'b000,
    IOSI_DIRECT   = 3'b001,
    IOSI_CAPTURE  = 3'b010,
    IOSI_TRANSFER = 3'b011,
    IOSI_DISABLE  = 3'b100
  } iosi_state_t;

endpackage

// *** test/iosi_sva.sv ***
`timescale 1ns/100ps
module iosi_sva (
  // Clock and reset
  input wire logic                          clk,
  input wire logic                          rst_n,
  // Link pins
  input wire logic [iosi_pkg::IOSI_NCH-1:0] channel_cmd,
  input wire logic                          load_n,
  input wire logic                          sync_n,
  input wire logic                          out_en,
  input wire logic                          fault_n,
  // Process side
  input wire logic [iosi_pkg::IOSI_NCH-1:0] channel_drive,
  input wire logic [iosi_pkg::IOSI_NCH-1:0] junction_trip,
  input wire logic                          case_trip,
  input wire logic                          barrier_corrupt
);
  import iosi_pkg::*;
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic [IOSI_NCH-1:0] cap;
  logic                sync_q;
  logic                load_q;
  logic                held_off;
  wire  quiet_w  = junction_trip == 8'h00 && !barrier_corrupt;
  wire  direct_w = !load_n && !sync_n && out_en && quiet_w;
  wire  capt_w   = !load_n && sync_n && out_en && quiet_w;
  // A release of both strobes together is a direct-mode release, not a
  // strobed apply, so the strobe must have been high the cycle before.
  wire  rise_w   = load_n && load_q && sync_n && !sync_q;
  wire  clear_w  = (!load_n && !sync_n) || rise_w;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cap      <= 8'h00;
      sync_q   <= 1'b1;
      load_q   <= 1'b1;
      held_off <= 1'b0;
    end else begin
      sync_q   <= sync_n;
      load_q   <= load_n;
      held_off <= !out_en || (held_off && !clear_w);
      if (!load_n && sync_n) begin
        cap <= channel_cmd;
      end
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence direct_s;
    direct_w [*4];
  endsequence
  sequence apply_s;
    rise_w && out_en && quiet_w;
  endsequence

  oe_off_a: assert property (
    !out_en |-> ##4 channel_drive == 8'h00)
    else $error("outputs not off after enable low");
  direct_follow_a: assert property (
    direct_s |-> ##1 channel_drive == $past(channel_cmd, 4))
    else $error("direct mode outputs do not follow commands");
  capture_hold_a: assert property (
    capt_w [*5] |-> $stable(channel_drive))
    else $error("outputs changed during capture");
  sync_apply_a: assert property (
    apply_s |-> ##4 channel_drive == $past(cap, 4))
    else $error("strobe release did not apply stored value");
  oe_clear_a: assert property (
    held_off [*6] |-> channel_drive == 8'h00)
    else $error("outputs back on without new sequence");
  fault_trip_a: assert property (
    (junction_trip != 8'h00 || case_trip) [*8] |-> ##[0:100] !fault_n)
    else $error("no fault on thermal trip");
  trip_gate_a: assert property (
    (junction_trip != 8'h00) [*4]
      |-> (channel_drive & $past(junction_trip, 3)) == 8'h00)
    else $error("tripped channel still driven");
  corrupt_off_a: assert property (
    barrier_corrupt [*8]
      |-> ##[0:100] (!fault_n && channel_drive == 8'h00))
    else $error("corruption did not fault and switch off");
endmodule // iosi_sva

// *** test/tb_isolated_octal_switch_input_interface.sv ***
`timescale 1ns/100ps
module tb_isolated_octal_switch_input_interface;
  import iosi_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                clk;
  logic                rst_n;
  logic                mode_direct;
  logic [IOSI_NCH-1:0] cmd_data;
  logic                update_req;
  logic                disable_req;
  logic                busy;
  logic                fault;
  logic [IOSI_NCH-1:0] channel_drive;
  logic [IOSI_NCH-1:0] junction_trip;
  logic                case_trip;
  logic                barrier_corrupt;
  int                  mismatches;
  int                  n_compared;

  iosi_if u_iosi_if ();
  // Short counts keep the run brief; transfer stays below sync time.
  iosi_host #(.SYNC_CYC(20), .OE_CYC(8)) u_iosi_host (
    .clk         (clk),
    .rst_n       (rst_n),
    .link        (u_iosi_if.host),
    .mode_direct (mode_direct),
    .cmd_data    (cmd_data),
    .update_req  (update_req),
    .disable_req (disable_req),
    .busy        (busy),
    .fault       (fault)
  );
  iosi_device #(.WD_CYC(400), .REFRESH_CYC(60), .XFER_CYC(4)) u_iosi_device (
    .clk             (clk),
    .rst_n           (rst_n),
    .link            (u_iosi_if.dev),
    .channel_drive   (channel_drive),
    .junction_trip   (junction_trip),
    .case_trip       (case_trip),
    .barrier_corrupt (barrier_corrupt)
  );
  iosi_sva u_iosi_sva (
    .clk             (clk),
    .rst_n           (rst_n),
    .channel_cmd     (u_iosi_if.channel_cmd),
    .load_n          (u_iosi_if.load_n),
    .sync_n          (u_iosi_if.sync_n),
    .out_en          (u_iosi_if.out_en),
    .fault_n         (u_iosi_if.fault_n),
    .channel_drive   (channel_drive),
    .junction_trip   (junction_trip),
    .case_trip       (case_trip),
    .barrier_corrupt (barrier_corrupt)
  );

  initial clk = 1'b0;
  always #10 clk = ~clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk_byte(input logic [IOSI_NCH-1:0] e,
                          input logic [IOSI_NCH-1:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic chk_bit(input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    step(2);
    while (busy !== 1'b0 && n < 2000) begin
      step(1);
      n++;
    end
    chk_bit(1'b0, busy);
  endtask
  task automatic req(input logic md, input logic [IOSI_NCH-1:0] d,
                     input logic dis);
    mode_direct = md;
    cmd_data = d;
    update_req = !dis;
    disable_req = dis;
    step(1);
    update_req = 1'b0;
    disable_req = 1'b0;
    wait_idle();
    step(6);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_direct();
    logic [IOSI_NCH-1:0] pat [3];
    pat = '{8'h01, 8'h80, 8'ha5};
    foreach (pat[i]) begin
      req(1'b1, pat[i], 1'b0);
      chk_byte(pat[i], channel_drive);
    end
    $display("test direct done");
  endtask
  task automatic t_strobed();
    int n;
    n = 0;
    req(1'b0, 8'h3c, 1'b0);
    chk_byte(8'h3c, channel_drive);
    cmd_data = 8'hc3;
    update_req = 1'b1;
    step(1);
    update_req = 1'b0;
    while (u_iosi_if.sync_n !== 1'b0 && n < 100) begin
      step(1);
      n++;
    end
    chk_bit(1'b1, u_iosi_if.load_n);
    chk_byte(8'h3c, channel_drive);
    wait_idle();
    step(6);
    chk_byte(8'hc3, channel_drive);
    $display("test strobed done");
  endtask
  task automatic t_disable();
    req(1'b0, 8'hff, 1'b0);
    disable_req = 1'b1;
    step(1);
    disable_req = 1'b0;
    step(6);
    chk_bit(1'b0, u_iosi_if.out_en);
    chk_byte(8'h00, channel_drive);
    wait_idle();
    step(20);
    chk_byte(8'h00, channel_drive);
    req(1'b0, 8'hff, 1'b0);
    chk_byte(8'hff, channel_drive);
    $display("test disable done");
  endtask
  task automatic t_refresh();
    req(1'b0, 8'h5a, 1'b0);
    step(500);
    chk_byte(8'h5a, channel_drive);
    $display("test refresh done");
  endtask
  task automatic t_fault();
    junction_trip = 8'h02;
    step(150);
    chk_bit(1'b1, fault);
    chk_bit(1'b0, u_iosi_if.fault_n);
    chk_byte(8'h58, channel_drive);
    junction_trip = 8'h00;
    case_trip = 1'b1;
    step(150);
    chk_bit(1'b1, fault);
    chk_byte(8'h5a, channel_drive);
    case_trip = 1'b0;
    step(150);
    chk_bit(1'b0, fault);
    $display("test fault done");
  endtask
  task automatic t_corrupt();
    barrier_corrupt = 1'b1;
    step(150);
    chk_bit(1'b1, fault);
    chk_byte(8'h00, channel_drive);
    barrier_corrupt = 1'b0;
    step(150);
    chk_bit(1'b0, fault);
    chk_byte(8'h5a, channel_drive);
    $display("test corrupt done");
  endtask

  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    mode_direct = 1'b0;
    cmd_data = 8'h00;
    update_req = 1'b0;
    disable_req = 1'b0;
    junction_trip = 8'h00;
    case_trip = 1'b0;
    barrier_corrupt = 1'b0;
    mismatches = 0;
    n_compared = 0;
    step(2);
    rst_n = 1'b1;
    t_direct();
    t_strobed();
    t_disable();
    t_refresh();
    t_fault();
    t_corrupt();
    summarize();
  end

  // The tests need about 1500 cycles; over six times that means a hang.
  initial begin
    #200000;
    mismatches++;
    summarize();
  end
endmodule // tb_isolated_octal_switch_input_interface
